// ### sdrct_pkg.sv
// What this block does
// - Column commands may come every cycle; each new one to an open bank is accepted while the clock is not suspended.
// - Clock enable low suspends the device one cycle later.
// - Clock enable high resumes the device one cycle later.
// - Write mask applies to the word sampled in the same cycle.
// - Read mask turns the data outputs off two cycles later.
// - First write word arrives with the write command and is sampled then.
// - Outputs turn off three cycles after a precharge that cuts a read.
`default_nettype none

package sdrct_pkg;

  // ==========================================================
  // Geometry and latencies
  localparam int SDRCT_CL       = 3;
  localparam int SDRCT_BL       = 4;
  localparam int SDRCT_DQZ_CYC  = 2;
  localparam int SDRCT_ROH_CYC  = 3;
  localparam int SDRCT_DQW      = 16;
  localparam int SDRCT_ADRW     = 13;
  localparam int SDRCT_BAW      = 2;
  localparam int SDRCT_NBANK    = 4;
  localparam int SDRCT_COLW     = 8;
  localparam int SDRCT_AP_BIT   = 10;
  localparam int SDRCT_MEM_DEP  = SDRCT_NBANK * (2 ** SDRCT_COLW);

  // ==========================================================
  // Reset values and last burst count
  localparam logic                     SDRCT_RST_EN   = 1'b1;
  localparam logic [SDRCT_NBANK-1:0]   SDRCT_RST_OPEN = 4'h0;
  localparam logic [1:0]               SDRCT_LAST_CNT = 2'(SDRCT_BL - 1);

  // ==========================================================
  // Commands
  typedef enum logic [6:0] {
    SDRCT_NOP   = 7'h01,
    SDRCT_ACT   = 7'h02,
    SDRCT_RD    = 7'h04,
    SDRCT_WR    = 7'h08,
    SDRCT_BST   = 7'h10,
    SDRCT_PRE   = 7'h20,
    SDRCT_OTHER = 7'h40
  } sdrct_cmd_t;

  typedef struct packed {
    logic                  cs_n;
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic [SDRCT_BAW-1:0]  ba;
    logic [SDRCT_ADRW-1:0] addr;
    logic [1:0]            dqm;
    logic [SDRCT_DQW-1:0]  dq;
  } sdrct_pins_t;

  typedef struct packed {
    logic                  act;
    logic                  wr;
    logic                  ap;
    logic [1:0]            cnt;
    logic [SDRCT_BAW-1:0]  ba;
    logic [SDRCT_COLW-1:0] col;
  } sdrct_burst_t;

  typedef struct packed {
    logic                   en;
    logic [SDRCT_NBANK-1:0] open;
    sdrct_burst_t           bst;
  } sdrct_state_t;

  function automatic sdrct_cmd_t sdrct_decode(input sdrct_pins_t p);
    logic [2:0] c;
    c = {p.ras_n, p.cas_n, p.we_n};
    if (p.cs_n) return SDRCT_NOP;
    unique case (c)
      3'h7: return SDRCT_NOP;
      3'h3: return SDRCT_ACT;
      3'h5: return SDRCT_RD;
      3'h4: return SDRCT_WR;
      3'h6: return SDRCT_BST;
      3'h2: return SDRCT_PRE;
      default: return SDRCT_OTHER;
    endcase
  endfunction

endpackage

`default_nettype wire

// ### sdrct_rdpipe.sv
`default_nettype none

module sdrct_rdpipe
  import sdrct_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_sync_n,
  // Core side
  input  wire logic                 adv,
  input  wire logic                 rd_vld,
  input  wire logic [SDRCT_DQW-1:0] rd_data,
  input  wire logic                 dqm_any,
  // Pins
  output logic      [SDRCT_DQW-1:0] dq_o,
  output logic                      dq_oe
);

  typedef struct packed {
    logic [SDRCT_CL-2:0]                vld;
    logic [SDRCT_CL-2:0][SDRCT_DQW-1:0] dat;
    logic                               dqm;
    logic                               oe;
    logic [SDRCT_DQW-1:0]               dout;
  } sdrct_pipe_t;

  sdrct_pipe_t s_q, s_d;

  // ==========================================================
  // Latency pipe; it freezes while the clock is suspended
  always_comb begin
    s_d = s_q;
    if (adv) begin
      s_d.vld[0] = rd_vld;
      s_d.dat[0] = rd_data;
      for (int i = 1; i < SDRCT_CL - 1; i++) begin
        s_d.vld[i] = s_q.vld[i-1];
        s_d.dat[i] = s_q.dat[i-1];
      end
      s_d.dqm  = dqm_any;
      // Mask seen one edge ago gates this edge's drive: two-cycle mask delay
      s_d.oe   = s_q.vld[SDRCT_CL-2] & ~s_q.dqm;
      s_d.dout = s_q.dat[SDRCT_CL-2];
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dq_o  = s_q.dout;
  assign dq_oe = s_q.oe;

  // ==========================================================
  // Checks
  read_mask_hz_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (dqm_any && adv) ##1 adv |-> ##1 !dq_oe)
    else $error("read mask did not turn outputs off two cycles later");

  read_latency_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (rd_vld && adv && !dqm_any) ##1 (adv && !dqm_any) ##1 adv |-> ##1 dq_oe)
    else $error("read data not driven at the read latency");

  read_data_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (rd_vld && adv) ##1 adv ##1 adv |-> ##1 (dq_o == $past(rd_data, 3)))
    else $error("read data word does not match the accessed word");

  masked_cov_c: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
    rd_vld && dqm_any ##2 dq_oe == 1'b0);

endmodule // sdrct_rdpipe

`default_nettype wire

// ### sdrct_core.sv
`default_nettype none

module sdrct_core
  import sdrct_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Command, address, mask and write data pins
  input  wire logic                 cke,
  input  wire sdrct_pins_t          pins_i,
  // Read data pins
  output logic      [SDRCT_DQW-1:0] dq_o,
  output logic                      dq_oe,
  // Status
  output logic                      suspended
);

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic       rst_sync_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_sync_q[1];

  // ==========================================================
  // Command decode and bank/burst control
  sdrct_state_t          st_q, st_d;
  sdrct_cmd_t            cmd;
  logic                  acc_vld;
  logic                  acc_wr;
  logic [SDRCT_BAW-1:0]  acc_ba;
  logic [SDRCT_COLW-1:0] acc_col;
  logic                  new_col;
  logic                  bst_cut;
  logic                  pre_cut_rd;
  logic                  ap_close;

  always_comb begin
    st_d       = st_q;
    // Clock enable acts on the edge after it is sampled
    st_d.en    = cke;
    cmd        = st_q.en ? sdrct_decode(pins_i) : SDRCT_NOP;
    acc_vld    = 1'b0;
    acc_wr     = 1'b0;
    acc_ba     = st_q.bst.ba;
    acc_col    = st_q.bst.col;
    ap_close   = 1'b0;
    new_col    = ((cmd == SDRCT_RD) || (cmd == SDRCT_WR)) && st_q.open[pins_i.ba];
    bst_cut    = st_q.bst.act && ((cmd == SDRCT_BST) || ((cmd == SDRCT_PRE) &&
                 (pins_i.addr[SDRCT_AP_BIT] || (pins_i.ba == st_q.bst.ba))));
    pre_cut_rd = bst_cut && (cmd == SDRCT_PRE) && !st_q.bst.wr;

    if (new_col) begin
      // A new column command always overrides a running burst
      acc_vld      = 1'b1;
      acc_wr       = (cmd == SDRCT_WR);
      acc_ba       = pins_i.ba;
      acc_col      = pins_i.addr[SDRCT_COLW-1:0];
      st_d.bst.act = (SDRCT_BL > 1);
      st_d.bst.wr  = acc_wr;
      st_d.bst.ap  = pins_i.addr[SDRCT_AP_BIT];
      st_d.bst.cnt = 2'h1;
      st_d.bst.ba  = pins_i.ba;
      st_d.bst.col = acc_col + 8'h01;
    end else if (bst_cut) begin
      // Word due this cycle is dropped, so reads drain in CL cycles
      st_d.bst.act = 1'b0;
    end else if (st_q.en && st_q.bst.act) begin
      acc_vld      = 1'b1;
      acc_wr       = st_q.bst.wr;
      st_d.bst.cnt = st_q.bst.cnt + 2'h1;
      st_d.bst.col = st_q.bst.col + 8'h01;
      if (st_q.bst.cnt == SDRCT_LAST_CNT) begin
        st_d.bst.act = 1'b0;
        ap_close     = st_q.bst.ap;
      end
    end

    if (ap_close) begin
      st_d.open[st_q.bst.ba] = 1'b0;
    end
    if (cmd == SDRCT_ACT) begin
      st_d.open[pins_i.ba] = 1'b1;
    end else if (cmd == SDRCT_PRE) begin
      if (pins_i.addr[SDRCT_AP_BIT]) begin
        st_d.open = SDRCT_RST_OPEN;
      end else begin
        st_d.open[pins_i.ba] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_q      <= '0;
      st_q.en   <= SDRCT_RST_EN;
      st_q.open <= SDRCT_RST_OPEN;
    end else begin
      st_q <= st_d;
    end
  end

  assign suspended = ~st_q.en;

  // ==========================================================
  // Storage; small window of columns per bank, rows share it
  logic [SDRCT_DQW-1:0]             mem [SDRCT_MEM_DEP];
  logic [SDRCT_BAW+SDRCT_COLW-1:0]  idx;

  assign idx = {acc_ba, acc_col};

  // One process owns the array; a process per byte lane would drive it twice
  always_ff @(posedge core_clk) begin
    for (int b = 0; b < 2; b++) begin
      // Mask and data are both taken in the cycle of the access
      if (acc_vld && acc_wr && !pins_i.dqm[b]) begin
        mem[idx][b*8 +: 8] <= pins_i.dq[b*8 +: 8];
      end
    end
  end

  sdrct_rdpipe u_rdpipe (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .adv        (st_q.en),
    .rd_vld     (acc_vld && !acc_wr),
    .rd_data    (mem[idx]),
    .dqm_any    (|pins_i.dqm),
    .dq_o       (dq_o),
    .dq_oe      (dq_oe)
  );

  // ==========================================================
  // Checks
  logic                             wr_chk_q;
  logic [SDRCT_BAW+SDRCT_COLW-1:0]  wr_idx_q;
  logic [SDRCT_DQW-1:0]             wr_dat_q;
  logic [1:0]                       wr_dqm_q;
  logic [SDRCT_DQW-1:0]             wr_old_q;

  always_ff @(posedge core_clk) begin
    wr_chk_q <= acc_vld && acc_wr && rst_sync_n;
    wr_idx_q <= idx;
    wr_dat_q <= pins_i.dq;
    wr_dqm_q <= pins_i.dqm;
    wr_old_q <= mem[idx];
  end

  cke_suspend_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    !cke |=> suspended ##0 (acc_vld == 1'b0 || new_col == 1'b0 && acc_vld == 1'b0))
    else $error("clock enable low did not suspend one cycle later");

  cke_resume_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    suspended && cke |=> !suspended)
    else $error("clock enable high did not resume one cycle later");

  suspend_hold_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    suspended |-> !acc_vld ##1 (st_q.open == $past(st_q.open)))
    else $error("device state moved while suspended");

  col_accept_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    new_col |-> acc_vld && (acc_col == pins_i.addr[SDRCT_COLW-1:0]) ##1
    (st_q.bst.ba == $past(pins_i.ba)))
    else $error("column command was not accepted in its cycle");

  write_now_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    wr_chk_q && wr_dqm_q == 2'h0 |-> mem[wr_idx_q] == wr_dat_q)
    else $error("write word not stored with zero delay");

  write_mask_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    wr_chk_q && wr_dqm_q == 2'h3 |-> mem[wr_idx_q] == wr_old_q)
    else $error("masked write word changed memory");

  pre_cut_hz_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    pre_cut_rd ##1 (st_q.en && !acc_vld)[*2] |-> ##1 !dq_oe)
    else $error("outputs still driven three cycles after precharge");

  burst_len_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (new_col && cke) ##1 (cmd == SDRCT_NOP && cke)[*3] |=> !st_q.bst.act)
    else $error("burst did not end after its length");

  // A column command to a closed bank must leave the burst logic idle
  closed_bank_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (cmd == SDRCT_RD || cmd == SDRCT_WR) && !st_q.open[pins_i.ba] && !st_q.bst.act
    |-> !acc_vld)
    else $error("column command to a closed bank was accepted");

  open_on_act_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    cmd == SDRCT_ACT |=> st_q.open[$past(pins_i.ba)])
    else $error("row open did not mark its bank open");

  // Auto precharge must close the bank right after the last burst word
  auto_close_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    ap_close && (cmd != SDRCT_ACT) |=> !st_q.open[$past(st_q.bst.ba)])
    else $error("auto precharge left the bank open");

  burst_stop_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (cmd == SDRCT_BST) && !new_col |=> !st_q.bst.act)
    else $error("burst stop did not end the burst");

  back_to_back_c: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
    new_col ##1 new_col ##1 new_col);

  pre_cut_c: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
    pre_cut_rd);

  suspend_c: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
    st_q.bst.act && suspended ##1 !suspended);

  auto_close_c: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
    ap_close);

endmodule // sdrct_core

`default_nettype wire

// ### sdrct_ctrl_model.sv
`default_nettype none

module sdrct_ctrl_model
  import sdrct_pkg::*;
(
  // Clock
  input  wire logic       core_clk,
  // Controller pins
  output var logic        cke,
  output var sdrct_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // ========
  // Spacing in 8 ns cycles, rounded up
  localparam int TRCD_CYC = 3;
  localparam int TRP_CYC  = 3;
  localparam int TMRD_CYC = 2;
  localparam int TRFC_CYC = 9;

  // Clock is suspended for one cycle on one read; self refresh stays unused, auto precharge is used on one read
  // Run is far shorter than one refresh interval; traffic spans all banks
  initial begin
    cke  = 1'b1;
    pins = '1;
  end

  task automatic drv(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                     input logic [15:0] d, input logic [1:0] m, input logic k);
    @(negedge core_clk);
    cke  = k;
    pins = sdrct_pins_t'({1'b0, c, b, a, m, d});
  endtask

  // Idle data lines toggle so a stale word never passes for data
  task automatic nop(input logic [1:0] m, input logic k);
    drv(3'h7, 2'h0, 13'h0, ~pins.dq, m, k);
  endtask

  task automatic idle(input int n);
    repeat (n) nop(2'h0, 1'b1);
  endtask

  task automatic init();
    idle(3);
    drv(3'h2, 2'h0, 13'h0400, ~pins.dq, 2'h0, 1'b1);
    idle(TRP_CYC - 1);
    repeat (2) begin
      drv(3'h1, 2'h0, 13'h0, ~pins.dq, 2'h0, 1'b1);
      idle(TRFC_CYC - 1);
    end
    drv(3'h0, 2'h0, 13'h0032, ~pins.dq, 2'h0, 1'b1);
    idle(TMRD_CYC - 1);
  endtask

  task automatic act(input logic [1:0] b);
    drv(3'h3, b, 13'h0, ~pins.dq, 2'h0, 1'b1);
    idle(TRCD_CYC - 1);
  endtask

  // Callers put reads between a write and any precharge
  task automatic wr(input logic [1:0] b, input logic [7:0] col,
                    input logic [3:0][15:0] d, input logic [1:0] m);
    drv(3'h4, b, {5'h0, col}, d[0], m, 1'b1);
    for (int i = 1; i < 4; i++) drv(3'h7, 2'h0, 13'h0, d[i], m, 1'b1);
  endtask
endmodule // sdrct_ctrl_model

`default_nettype wire

// ### tb_sdram_command_timing.sv
`default_nettype none

module tb_sdram_command_timing
  import sdrct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [1:0]  ba;
    logic [7:0]  col;
    logic [15:0] d;
    logic [1:0]  m;
    logic [15:0] e0;
  } sdrct_row_t;

  logic                 core_clk;
  logic                 rst_n;
  logic                 cke;
  sdrct_pins_t          pins;
  logic [SDRCT_DQW-1:0] dq_o;
  logic                 dq_oe;
  logic                 suspended;
  int                   errors;
  int                   compares;
  logic [3:0][15:0]     wd;
  logic [3:0][15:0]     nw;
  logic [4:0][15:0]     ex [4];
  logic [4:0][15:0]     e5;
  // Command that cuts a read at pj, and the upper address bits of a read
  logic [2:0]           cut = 3'h2;
  logic [4:0]           ap  = 5'h00;

  // Second write flips every bit; masked bytes keep the first
  sdrct_row_t rows [4] = '{
    '{2'h0, 8'h10, 16'h1234, 2'h0, 16'hedcb},
    '{2'h1, 8'hfe, 16'ha5a0, 2'h1, 16'h5aa0},
    '{2'h2, 8'h40, 16'h0f00, 2'h2, 16'h0fff},
    '{2'h3, 8'h80, 16'h7700, 2'h3, 16'h7700}
  };

  always #4 core_clk = ~core_clk;

  sdrct_ctrl_model ctl_u (
    .core_clk (core_clk),
    .cke      (cke),
    .pins     (pins)
  );

  sdrct_core dut_u (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .cke       (cke),
    .pins_i    (pins),
    .dq_o      (dq_o),
    .dq_oe     (dq_oe),
    .suspended (suspended)
  );

  task automatic cmp(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] merge(input logic [15:0] d, input logic [1:0] m);
    return {m[1] ? d[15:8] : ~d[15:8], m[0] ? d[7:0] : ~d[7:0]};
  endfunction

  // ========
  // Read check: n words (5 = repeated read), mask at mj, cut command at pj,
  // clock enable low at sj; 99 leaves an option out
  task automatic rdchk(input logic [1:0] b, input logic [7:0] col, input int n,
                       input int mj, input int pj, input int sj, input logic [4:0][15:0] e);
    int   s;
    logic want;
    s = (sj < 99) ? 1 : 0;
    ctl_u.drv(3'h5, b, {ap, col}, ~pins.dq, 2'h0, 1'b1);
    for (int j = 1; j <= n + SDRCT_CL + s; j++) begin
      if ((n == 5 && j == 1) || j == sj + 1) begin
        ctl_u.drv(3'h5, b, {5'h0, col + 8'(s)}, ~pins.dq, 2'h0, 1'b1);
      end else if (j == pj) begin
        ctl_u.drv(cut, b, 13'h0, ~pins.dq, 2'h0, 1'b1);
      end else begin
        ctl_u.nop((j == mj) ? 2'h3 : 2'h0, j != sj);
      end
      want = j >= SDRCT_CL + s && j < SDRCT_CL + s + n && j != mj + SDRCT_DQZ_CYC &&
             j < pj + SDRCT_ROH_CYC;
      cmp("dq_oe", 16'(dq_oe), 16'(want));
      if (want) cmp("dq_o", dq_o, e[j - SDRCT_CL - s]);
      if (j == sj + 1) cmp("suspended", 16'(suspended), 16'h1);
      if (j == sj + 2) cmp("suspended", 16'(suspended), 16'h0);
    end
  endtask

  initial begin
    core_clk = 1'b0;
    rst_n    = 1'b0;
    errors   = 0;
    compares = 0;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    cmp("dq_oe", 16'(dq_oe), 16'h0);
    cmp("suspended", 16'(suspended), 16'h0);
    ctl_u.init();
    for (int r = 0; r < 4; r++) ctl_u.act(rows[r].ba);
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 4; i++) begin
        wd[i]    = rows[r].d + 16'(i);
        nw[i]    = ~wd[i];
        ex[r][i] = (i == 0) ? rows[r].e0 : merge(wd[i], rows[r].m);
      end
      ctl_u.wr(rows[r].ba, rows[r].col, wd, 2'h0);
      ctl_u.wr(rows[r].ba, rows[r].col, nw, rows[r].m);
      rdchk(rows[r].ba, rows[r].col, 4, 99, 99, 99, ex[r]);
    end
    // ========
    // Awkward cases
    e5 = {ex[1][3:0], ex[1][0]};
    rdchk(2'h1, 8'hfe, 5, 99, 99, 99, e5);
    rdchk(2'h0, 8'h10, 4, 1, 99, 99, ex[0]);
    rdchk(2'h2, 8'h40, 4, 99, 99, 1, ex[2]);
    rdchk(2'h3, 8'h80, 4, 99, 2, 99, ex[3]);
    rdchk(2'h3, 8'h80, 0, 99, 99, 99, ex[3]);
    ctl_u.act(2'h3);
    rdchk(2'h3, 8'h80, 4, 99, 99, 99, ex[3]);
    // Burst stop ends the read but leaves the bank open
    cut = 3'h6;
    rdchk(2'h0, 8'h10, 4, 99, 2, 99, ex[0]);
    rdchk(2'h0, 8'h10, 4, 99, 99, 99, ex[0]);
    // Auto precharge read closes its bank, so the next read is ignored
    ap = 5'h04;
    rdchk(2'h2, 8'h40, 4, 99, 99, 99, ex[2]);
    ap = 5'h00;
    rdchk(2'h2, 8'h40, 0, 99, 99, 99, ex[2]);
    test_done();
  end
endmodule // tb_sdram_command_timing

`default_nettype wire
